// ==== fram_i2c_slave.sv ====
// fram_i2c_slave.sv: i2c target of a 2k x 8 nonvolatile memory
// assumes linkClk samples the bus far faster than scl; srst on clk
`include "fram_cfg.svh"

module fram_afifo #(
   parameter int WIDTH = $bits(fram_pkg::fram_wr_s),
   parameter int DEPTH = `FRAM_FIFO_DEPTH
) (
   input wire logic wrClk,
   input wire logic wrRst,
   input wire logic wrValid,
   output logic wrReady,
   input wire logic [WIDTH-1:0] wrData,
   input wire logic rdClk,
   input wire logic rdRst,
   output logic rdValid,
   input wire logic rdReady,
   output logic [WIDTH-1:0] rdData
);
   localparam int AW = $clog2(DEPTH);
   if (DEPTH < 4 || (1 << AW) != DEPTH) begin : bad_depth
      $error("fifo depth must be a power of two, at least 4");
   end

   function automatic logic [AW:0] toGray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction : toGray

   logic [WIDTH-1:0] store [DEPTH];
   logic [AW:0] wrBin_ff;
   logic [AW:0] wrGray_ff;
   logic [AW:0] rdBin_ff;
   logic [AW:0] rdGray_ff;
   logic [AW:0] rgMeta_ff;
   logic [AW:0] rgSync_ff;
   logic [AW:0] wgMeta_ff;
   logic [AW:0] wgSync_ff;
   logic [AW:0] nxt_wrBin;
   logic [AW:0] nxt_rdBin;
   logic push;
   logic pop;

   // gray pointers: only one bit moves per step across the crossing
   assign wrReady = wrGray_ff != {~rgSync_ff[AW:AW-1], rgSync_ff[AW-2:0]};
   assign rdValid = rdGray_ff != wgSync_ff;
   assign push = wrValid && wrReady;
   assign pop = rdValid && rdReady;
   assign nxt_wrBin = wrBin_ff + (AW+1)'(push);
   assign nxt_rdBin = rdBin_ff + (AW+1)'(pop);
   assign rdData = store[rdBin_ff[AW-1:0]];

   always_ff @(posedge wrClk) begin
      if (push) begin
         store[wrBin_ff[AW-1:0]] <= wrData;
      end
   end

   always_ff @(posedge wrClk) begin
      if (wrRst) begin
         wrBin_ff <= '0;
         wrGray_ff <= '0;
      end else begin
         wrBin_ff <= nxt_wrBin;
         wrGray_ff <= toGray(nxt_wrBin);
      end
   end

   always_ff @(posedge wrClk) begin
      if (wrRst) begin
         {rgSync_ff, rgMeta_ff} <= '0;
      end else begin
         {rgSync_ff, rgMeta_ff} <= {rgMeta_ff, rdGray_ff};
      end
   end

   always_ff @(posedge rdClk) begin
      if (rdRst) begin
         rdBin_ff <= '0;
         rdGray_ff <= '0;
      end else begin
         rdBin_ff <= nxt_rdBin;
         rdGray_ff <= toGray(nxt_rdBin);
      end
   end

   always_ff @(posedge rdClk) begin
      if (rdRst) begin
         {wgSync_ff, wgMeta_ff} <= '0;
      end else begin
         {wgSync_ff, wgMeta_ff} <= {wgMeta_ff, wrGray_ff};
      end
   end
endmodule : fram_afifo

module fram_i2c_slave #(
   parameter logic [3:0] DEV_TYPE = `FRAM_DEVTYPE_RST, // arbitrary value
   parameter int FIFO_DEPTH = `FRAM_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic linkClk,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic wpIn,
   output logic sdaOut,
   output logic sdaOe
);
   if (`FRAM_SCL_SAMPLES < `FRAM_MIN_SAMPLES) begin : bad_rate
      $error("link clock too slow for a 1 MHz bus");
   end

   logic lnkRstMeta_ff;
   logic lnkRst_ff;
   logic sclMeta_ff;
   logic sclSync_ff;
   logic sclPrev_ff;
   logic sdaMeta_ff;
   logic sdaSync_ff;
   logic sdaPrev_ff;
   logic wpMeta_ff;
   logic wpSync_ff;
   logic sclRise;
   logic sclFall;
   logic startDet;
   logic stopDet;
   fram_pkg::fram_state_e state_ff;
   fram_pkg::fram_state_e nxt_state;
   logic [3:0] bitCnt_ff;
   logic [6:0] rxShift_ff;
   logic [7:0] rxByte;
   logic [7:0] txShift_ff;
   logic [7:0] nxt_txShift;
   logic [7:0] rdData_ff;
   fram_pkg::fram_dev_s dev;
   logic devHit;
   logic lastBit;
   logic ackRise;
   logic ackFlag_ff;
   logic rw_ff;
   logic accept;
   logic [`FRAM_ADDR_W-1:0] addrPtr_ff;
   logic [`FRAM_ADDR_W-1:0] rdAddr_ff;
   logic rdReqTgl_ff;
   logic rdAckMeta_ff;
   logic rdAckSync_ff;
   logic rdAckTgl_ff;
   logic rdLinkReady;
   logic sdaOe_ff;
   logic fifoWrValid;
   logic fifoWrReady;
   fram_pkg::fram_wr_s fifoWrData;

   // link side reset follows srst; no other supervision exists
   always_ff @(posedge linkClk) begin
      lnkRstMeta_ff <= srst;
      lnkRst_ff <= lnkRstMeta_ff;
   end

   // pins reach logic only after two flops; idle bus is high
   always_ff @(posedge linkClk) begin
      if (lnkRst_ff) begin
         {sclPrev_ff, sclSync_ff, sclMeta_ff} <= 3'h7;
         {sdaPrev_ff, sdaSync_ff, sdaMeta_ff} <= 3'h7;
         {wpSync_ff, wpMeta_ff} <= 2'h0;
      end else begin
         {sclPrev_ff, sclSync_ff, sclMeta_ff} <=
            {sclSync_ff, sclMeta_ff, sclIn};
         {sdaPrev_ff, sdaSync_ff, sdaMeta_ff} <=
            {sdaSync_ff, sdaMeta_ff, sdaIn};
         {wpSync_ff, wpMeta_ff} <= {wpMeta_ff, wpIn};
      end
   end

   // oversampled edges; at 32 ns sampling a 1 MHz bus has ample margin
   assign sclRise = sclSync_ff && !sclPrev_ff;
   assign sclFall = !sclSync_ff && sclPrev_ff;
   assign startDet = sclSync_ff && sclPrev_ff && sdaPrev_ff && !sdaSync_ff;
   assign stopDet = sclSync_ff && sclPrev_ff && !sdaPrev_ff && sdaSync_ff;

   assign rxByte = {rxShift_ff, sdaSync_ff};
   assign dev = fram_pkg::fram_dev_s'(rxByte);
   assign devHit = dev.devType == DEV_TYPE;
   assign lastBit = sclRise && bitCnt_ff == `FRAM_LAST_BIT;
   assign ackRise = sclRise && bitCnt_ff == `FRAM_ACK_BIT;
   // protected data is acked but dropped; full fifo refuses with nack
   assign accept = wpSync_ff || fifoWrReady;
   assign rdLinkReady = rdAckSync_ff == rdReqTgl_ff;

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff || startDet || stopDet) begin
         bitCnt_ff <= 4'h0;
      end else if (sclRise) begin
         bitCnt_ff <= (bitCnt_ff == `FRAM_ACK_BIT) ? 4'h0 : bitCnt_ff + 4'h1;
      end
   end

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff) begin
         rxShift_ff <= 7'h00;
      end else if (sclRise && bitCnt_ff != `FRAM_ACK_BIT) begin
         rxShift_ff <= rxByte[6:0];
      end
   end

   always_comb begin
      nxt_state = fram_pkg::ST_IDLE;
      case (state_ff)
         fram_pkg::ST_DEV: begin
            if (ackFlag_ff) begin
               nxt_state = rw_ff ? fram_pkg::ST_READ : fram_pkg::ST_WORD;
            end
         end
         fram_pkg::ST_WORD, fram_pkg::ST_WRITE: begin
            if (ackFlag_ff) begin
               nxt_state = fram_pkg::ST_WRITE;
            end
         end
         fram_pkg::ST_READ: begin
            if (!sdaSync_ff) begin
               nxt_state = fram_pkg::ST_READ;
            end
         end
         default: begin
            nxt_state = fram_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff || stopDet) begin
         state_ff <= fram_pkg::ST_IDLE;
      end else if (startDet) begin
         state_ff <= fram_pkg::ST_DEV;
      end else if (ackRise) begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff || startDet) begin
         ackFlag_ff <= 1'b0;
         rw_ff <= 1'b0;
      end else if (lastBit) begin
         case (state_ff)
            fram_pkg::ST_DEV: begin
               ackFlag_ff <= devHit;
               rw_ff <= dev.rw;
            end
            fram_pkg::ST_WORD: ackFlag_ff <= 1'b1;
            fram_pkg::ST_WRITE: ackFlag_ff <= accept;
            default: ackFlag_ff <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff) begin
         addrPtr_ff <= `FRAM_ADDR_RST;
      end else if (lastBit) begin
         case (state_ff)
            fram_pkg::ST_DEV: addrPtr_ff <= {dev.page, addrPtr_ff[7:0]};
            fram_pkg::ST_WORD: addrPtr_ff <= {addrPtr_ff[10:8], rxByte};
            fram_pkg::ST_WRITE: begin
               if (accept) begin
                  addrPtr_ff <= addrPtr_ff + 11'h001;
               end
            end
            fram_pkg::ST_READ: addrPtr_ff <= addrPtr_ff + 11'h001;
            default: addrPtr_ff <= addrPtr_ff;
         endcase
      end
   end

   // fetch is requested half a bit or more before the byte is sent
   always_ff @(posedge linkClk) begin
      if (lnkRst_ff) begin
         rdAddr_ff <= `FRAM_ADDR_RST;
         rdReqTgl_ff <= 1'b0;
      end else if (lastBit && state_ff == fram_pkg::ST_DEV && devHit
            && dev.rw) begin
         rdAddr_ff <= {dev.page, addrPtr_ff[7:0]};
         rdReqTgl_ff <= !rdReqTgl_ff;
      end else if (ackRise && state_ff == fram_pkg::ST_READ && !sdaSync_ff) begin
         rdAddr_ff <= addrPtr_ff;
         rdReqTgl_ff <= !rdReqTgl_ff;
      end
   end

   // the write is handed off at the last bit, before the ack is driven
   assign fifoWrValid = lastBit && state_ff == fram_pkg::ST_WRITE
      && !wpSync_ff;
   assign fifoWrData = {addrPtr_ff, rxByte};

   assign nxt_txShift = (bitCnt_ff == 4'h0) ? rdData_ff
      : {txShift_ff[6:0], 1'b0};

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff || startDet || stopDet) begin
         sdaOe_ff <= 1'b0;
         txShift_ff <= 8'h00;
      end else if (sclFall) begin
         if (bitCnt_ff == `FRAM_ACK_BIT) begin
            sdaOe_ff <= ackFlag_ff && state_ff != fram_pkg::ST_READ;
         end else if (state_ff == fram_pkg::ST_READ) begin
            sdaOe_ff <= !nxt_txShift[7];
            txShift_ff <= nxt_txShift;
         end else begin
            sdaOe_ff <= 1'b0;
         end
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_ff;

   always_ff @(posedge linkClk) begin
      if (lnkRst_ff) begin
         {rdAckSync_ff, rdAckMeta_ff} <= 2'h0;
      end else begin
         {rdAckSync_ff, rdAckMeta_ff} <= {rdAckMeta_ff, rdAckTgl_ff};
      end
   end

   // memory side on clk
   localparam int SERVE_MAX = `FRAM_SERVE_MAX;
   logic [7:0] mem [`FRAM_ROWS][`FRAM_SEGS];
   logic reqMeta_ff;
   logic reqSync_ff;
   logic popValid;
   logic popReady;
   logic rdServe;
   fram_pkg::fram_wr_s popWord;
   fram_pkg::fram_addr_s rdLoc;

   fram_afifo #(
      .WIDTH($bits(fram_pkg::fram_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .wrClk(linkClk),
      .wrRst(lnkRst_ff),
      .wrValid(fifoWrValid),
      .wrReady(fifoWrReady),
      .wrData(fifoWrData),
      .rdClk(clk),
      .rdRst(srst),
      .rdValid(popValid),
      .rdReady(popReady),
      .rdData(popWord)
   );

   always_ff @(posedge clk) begin
      if (srst) begin
         {reqSync_ff, reqMeta_ff} <= 2'h0;
      end else begin
         {reqSync_ff, reqMeta_ff} <= {reqMeta_ff, rdReqTgl_ff};
      end
   end

   // reads wait for queued writes so they always see the latest data
   assign rdServe = reqSync_ff != rdAckTgl_ff && !popValid;
   assign popReady = !rdServe;
   // address is held still by the link until the toggle returns
   assign rdLoc = fram_pkg::fram_addr_s'(rdAddr_ff);

   always_ff @(posedge clk) begin
      if (popValid && popReady) begin
         mem[popWord.addr.row][popWord.addr.seg] <=
            popWord.data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdData_ff <= 8'h00;
         rdAckTgl_ff <= 1'b0;
      end else if (rdServe) begin
         rdData_ff <= mem[rdLoc.row][rdLoc.seg];
         rdAckTgl_ff <= reqSync_ff;
      end
   end

   start_abort_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      startDet |=> state_ff == fram_pkg::ST_DEV && bitCnt_ff == 4'h0
         && !sdaOe_ff)
      else $error("start did not restart the transfer");

   stop_idle_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      stopDet |=> state_ff == fram_pkg::ST_IDLE && !sdaOe_ff)
      else $error("stop did not idle the target");

   oe_on_fall_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      (sdaOe_ff != $past(sdaOe_ff)) |-> $past(sclFall || startDet || stopDet))
      else $error("data pin changed away from a falling edge");

   bit_on_rise_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      (bitCnt_ff != $past(bitCnt_ff))
         |-> $past(sclRise || startDet || stopDet))
      else $error("bit count moved without a rising edge");

   wp_block_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      wpSync_ff && lastBit && state_ff == fram_pkg::ST_WRITE
         |-> !fifoWrValid ##1 ackFlag_ff)
      else $error("protected byte queued or not acknowledged");

   addr_wrap_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      lastBit && state_ff == fram_pkg::ST_READ && addrPtr_ff == `FRAM_ADDR_TOP
         |=> addrPtr_ff == `FRAM_ADDR_RST)
      else $error("address did not wrap to zero");

   nack_end_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      ackRise && state_ff == fram_pkg::ST_READ && sdaSync_ff
         |=> state_ff == fram_pkg::ST_IDLE && !sdaOe_ff)
      else $error("read went on after a nack");

   dev_match_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      lastBit && state_ff == fram_pkg::ST_DEV |=> ackFlag_ff == $past(devHit))
      else $error("address byte decode wrong");

   data_ready_a: assert property (
      @(posedge linkClk) disable iff (lnkRst_ff)
      sclFall && state_ff == fram_pkg::ST_READ && bitCnt_ff == 4'h0
         |-> rdLinkReady)
      else $error("read byte not fetched in time");

   commit_write_a: assert property (
      @(posedge clk) disable iff (srst)
      popValid && popReady |=> mem[$past(popWord.addr.row)]
         [$past(popWord.addr.seg)] == $past(popWord.data))
      else $error("popped byte not stored");

   serve_bound_a: assert property (
      @(posedge clk) disable iff (srst)
      reqSync_ff != rdAckTgl_ff |-> ##[1:SERVE_MAX] reqSync_ff == rdAckTgl_ff)
      else $error("read fetch took too long");

   write_commit_c: cover property (@(posedge clk) disable iff (srst)
      popValid && popReady);
   read_serve_c: cover property (@(posedge clk) disable iff (srst) rdServe);
   wp_discard_c: cover property (@(posedge linkClk) disable iff (lnkRst_ff)
      wpSync_ff && lastBit && state_ff == fram_pkg::ST_WRITE);
   read_burst_c: cover property (@(posedge linkClk) disable iff (lnkRst_ff)
      ackRise && state_ff == fram_pkg::ST_READ && !sdaSync_ff);
endmodule : fram_i2c_slave

// ==== fram_cfg.svh ====
// fram_cfg.svh: constants of the serial fram target
// assumes it is included by fram_pkg.sv and fram_i2c_slave.sv only
// Notes on behaviour
// - the array holds 2048 bytes, each picked by one 11-bit address.
// - eight upper address bits pick one of 256 rows.
// - three low address bits pick one of eight segments in the row.
// - bytes cross the link one bit at a time, both directions.
// - sample data on the rising clock edge, change it on the falling.
// - the data pin is only pulled low or released, never driven high.
// - with write protect high, no stored byte ever changes.
// - with write protect low all addresses accept writes; pin idles low.
// - each received data byte is committed right after its last bit.
// - writes finish before the next transaction, so no busy polling.
// - control state is set by a plain power-on reset only.
// - bus clock rates up to 1 MHz, plus 100 and 400 kHz, work.
// - address byte holds type, page and read flag; the target decodes it.
// - the byte address steps after each byte and wraps 7ffh to 000h.
// - reads go on while the master acknowledges; its nack ends them.
// - start or stop aborts any operation; start readies a new one.
`ifndef FRAM_CFG_SVH
`define FRAM_CFG_SVH
`define FRAM_ADDR_W 11
`define FRAM_ROW_W 8
`define FRAM_SEG_W 3
`define FRAM_DATA_W 8
`define FRAM_ROWS 256
`define FRAM_SEGS 8
`define FRAM_LAST_BIT 4'h7
`define FRAM_ACK_BIT 4'h8
`define FRAM_FIFO_DEPTH 32
`define FRAM_DEVTYPE_RST 4'h5
`define FRAM_ADDR_RST 11'h000
`define FRAM_ADDR_TOP 11'h7ff
`define FRAM_SCL_MIN_NS 1000
`define FRAM_LINK_NS 32
`define FRAM_SCL_SAMPLES (`FRAM_SCL_MIN_NS / `FRAM_LINK_NS)
`define FRAM_MIN_SAMPLES 8
`define FRAM_SERVE_MAX 40
`endif

// ==== fram_pkg.sv ====
// fram_pkg.sv: types shared by the serial fram target
// assumes fram_cfg.svh on the include path
`include "fram_cfg.svh"
package fram_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_WORD = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ = 3'b100
   } fram_state_e;

   typedef struct packed {
      logic [`FRAM_ROW_W-1:0] row;
      logic [`FRAM_SEG_W-1:0] seg;
   } fram_addr_s;

   typedef struct packed {
      fram_addr_s addr;
      logic [`FRAM_DATA_W-1:0] data;
   } fram_wr_s;

   typedef struct packed {
      logic [3:0] devType;
      logic [2:0] page;
      logic rw;
   } fram_dev_s;
endpackage : fram_pkg

// ==== fram_bus_master.sv ====
// fram_bus_master.sv: behavioural i2c bus master facing the fram target
// assumes the bench resolves a pulled-up data wire; clk runs at 100 MHz
module fram_bus_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sdaLow,
   output logic rxValid,
   output logic [7:0] rxData
);
   timeunit 1ns;
   timeprecision 1ns;
   // clk cycles per scl half period, set by the bench for each bus rate
   int half = 50;

   initial begin
      scl = 1'b1; // idle high, no clocks outside frames
      sdaLow = 1'b0;
      rxValid = 1'b0;
      rxData = 8'h00;
   end

   task automatic waitClk(input int n);
      repeat (n) @(negedge clk);
   endtask : waitClk

   task automatic post(input logic [7:0] v);
      rxData = v;
      rxValid = 1'b1;
      waitClk(1);
      rxValid = 1'b0;
   endtask : post

   // also a repeated start; sda moves half/2 after scl fell (hold time)
   task automatic startCond;
      sdaLow = 1'b0;
      waitClk(half / 2);
      scl = 1'b1;
      waitClk(half);
      sdaLow = 1'b1;
      waitClk(half / 2);
      scl = 1'b0;
      waitClk(half / 2);
   endtask : startCond

   task automatic stopCond;
      sdaLow = 1'b1;
      waitClk(half / 2);
      scl = 1'b1;
      waitClk(half);
      sdaLow = 1'b0;
      waitClk(half);
   endtask : stopCond

   // data held through the whole high phase, sampled in its middle
   task automatic sendBit(input logic b, output logic s);
      sdaLow = ~b;
      waitClk(half / 2);
      scl = 1'b1;
      waitClk(half / 2);
      s = sda;
      waitClk(half / 2);
      scl = 1'b0;
      waitClk(half / 2);
   endtask : sendBit

   // msb first, then the target's acknowledge is reported
   task automatic wrByte(input logic [7:0] b);
      logic [7:0] rx;
      logic ack;
      for (int i = 7; i >= 0; i--) sendBit(b[i], rx[i]);
      sendBit(1'b1, ack);
      post({7'h00, ack});
   endtask : wrByte

   // released data line; nack on the last byte ends the read
   task automatic rdByte(input logic last);
      logic [7:0] rx;
      logic ack;
      for (int i = 7; i >= 0; i--) sendBit(1'b1, rx[i]);
      sendBit(last, ack);
      post(rx);
   endtask : rdByte
endmodule : fram_bus_master

// ==== fram_i2c_slave_tb.sv ====
// fram_i2c_slave_tb.sv: self-checking bench of the serial fram target
// assumes fram_pkg, fram_i2c_slave and fram_bus_master are compiled first
module fram_i2c_slave_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] DEV = 4'h9; // arbitrary device type
   logic clk = 1'b0;
   logic linkClk = 1'b0;
   logic srst = 1'b1;
   logic wpIn = 1'b0; // stands in for the internal pull-down
   logic scl;
   logic sdaLow;
   logic sda;
   logic sdaOut;
   logic sdaOe;
   logic rxValid;
   logic [7:0] rxData;
   logic [7:0] expQ[$];
   int n_fail = 0;
   int compares = 0;

   always #5 clk = ~clk;
   initial begin
      #3;
      forever #16 linkClk = ~linkClk;
   end
   // open drain wire with pull-up
   assign sda = ~(sdaLow | (sdaOe & ~sdaOut));

   fram_i2c_slave #(.DEV_TYPE(DEV)) uut (
      .clk(clk),
      .srst(srst),
      .linkClk(linkClk),
      .sclIn(scl),
      .sdaIn(sda),
      .wpIn(wpIn),
      .sdaOut(sdaOut),
      .sdaOe(sdaOe)
   );

   fram_bus_master m (
      .clk(clk),
      .sda(sda),
      .scl(scl),
      .sdaLow(sdaLow),
      .rxValid(rxValid),
      .rxData(rxData)
   );

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic results;
      if (n_fail == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : results

   // oldest note is compared with each reported bus result
   always @(posedge clk) begin
      if (rxValid === 1'b1) begin
         check("bus result", rxData,
               (expQ.size() > 0) ? expQ.pop_front() : 8'hxx);
      end
      if (sdaOe === 1'b1) begin
         check("data pin value", {7'h00, sdaOut}, 8'h00);
      end
   end

   task automatic wrAck(input logic [7:0] b, input logic a);
      expQ.push_back({7'h00, a});
      m.wrByte(b);
   endtask : wrAck

   task automatic setPtr(input logic [10:0] a);
      m.startCond();
      wrAck({DEV, a[10:8], 1'b0}, 1'b0);
      wrAck(a[7:0], 1'b0);
   endtask : setPtr

   task automatic writeMem(input logic [10:0] a, input logic [7:0] d[$]);
      setPtr(a);
      foreach (d[i]) wrAck(d[i], 1'b0);
      m.stopCond();
   endtask : writeMem

   // repeated start straight after addressing, no busy polling
   task automatic readMem(input logic [10:0] a, input logic [7:0] d[$]);
      setPtr(a);
      m.startCond();
      wrAck({DEV, a[10:8], 1'b1}, 1'b0);
      foreach (d[i]) begin
         expQ.push_back(d[i]);
         m.rdByte(i == d.size() - 1);
      end
      m.stopCond();
   endtask : readMem

   initial begin
      logic [7:0] d[$];
      logic [10:0] a;
      logic s;
      int seed;
      seed = $urandom(32'he001ca03);
      // link reset trails by two flops, so it still spans two edges
      repeat (8) @(negedge clk);
      srst = 1'b0;
      repeat (20) @(negedge clk);
      d = '{8'($urandom), 8'($urandom), 8'($urandom)};
      writeMem(11'h7fe, d);
      readMem(11'h7fe, d);
      m.startCond();
      wrAck({~DEV, 3'h0, 1'b0}, 1'b1);
      m.stopCond();
      a = 11'h123;
      d = '{8'h5a};
      writeMem(a, d);
      wpIn = 1'b1;
      d = '{8'ha5};
      writeMem(a, d);
      wpIn = 1'b0;
      d = '{8'h5a};
      readMem(a, d);
      d = '{8'hc3, 8'h3c};
      writeMem(a, d);
      readMem(a, d);
      // a byte cut short by start, then by stop, is never written
      d = '{8'h11};
      writeMem(11'h234, d);
      setPtr(11'h234);
      for (int i = 0; i < 3; i++) m.sendBit(1'b0, s);
      m.startCond();
      wrAck({DEV, 3'h2, 1'b1}, 1'b0);
      expQ.push_back(8'h11);
      m.rdByte(1'b1);
      setPtr(11'h234);
      for (int i = 0; i < 5; i++) m.sendBit(1'b0, s);
      m.stopCond();
      readMem(11'h234, d);
      // slower legacy rate with a random place and random data
      m.half = 125;
      a = 11'($urandom);
      d = '{8'($urandom), 8'($urandom)};
      writeMem(a, d);
      readMem(a, d);
      m.half = 50;
      repeat (4) @(negedge clk);
      check("pending results", 8'(expQ.size()), 8'h00);
      results();
   end

   // whole sequence needs about 66000 clk cycles
   initial begin
      repeat (96000) @(posedge clk);
      n_fail++;
      results();
   end
endmodule : fram_i2c_slave_tb
